// ### design/pzs_defs.svh
// Timing and reset constants for the pipelined zero-turnaround SRAM ends.
// Assumes inclusion by bare name from files under design/.
`ifndef PZS_DEFS_SVH
`define PZS_DEFS_SVH

// Data follows address and control by this many cycles
`define PZS_DATA_LAT    2
// Words delivered per supplied address in a burst
`define PZS_BURST_LEN   4
// Width of the internal burst counter
`define PZS_CNT_W       2
// Default widths: 512K words of four 9-bit lanes
`define PZS_ADDR_W      19
`define PZS_NBYTES      4
`define PZS_BYTE_W      9
// Reset values
`define PZS_CNT_RST     2'h0
`define PZS_FLAG_RST    1'h0
`define PZS_PIN_HI_RST  1'h1

`endif

// ### design/pzs_pkg.sv
// Shared types for both ends of the pipelined SRAM link.
// Assumes nothing beyond a SystemVerilog compiler.
package pzs_pkg;

  // Operation carried along the data pipeline
  typedef enum logic [1:0] {
    PZS_OP_NONE  = 2'h0,
    PZS_OP_READ  = 2'h1,
    PZS_OP_WRITE = 2'h2
  } pzs_op_e;

  // Level of the static burst-order pin
  typedef enum logic {
    PZS_ORDER_INTERLEAVED = 1'h0,
    PZS_ORDER_LINEAR      = 1'h1
  } pzs_order_e;

endpackage

// ### design/pzs_sram_if.sv
// Pin-level link between the memory controller and the SRAM device.
// Assumes both ends share one clock; the data bus level is resolved here.
`timescale 1ns/10ps
interface pzs_sram_if #(
  parameter int ADDR_W = 19,
  parameter int NBYTES = 4,
  parameter int BYTE_W = 9
);
  localparam int DW = NBYTES * BYTE_W;

  logic [ADDR_W-1:0]     addr;
  logic                  clk_enable_n;
  logic                  advance_load_n;
  logic                  chip_sel1_n;
  logic                  chip_sel2;
  logic                  chip_sel3_n;
  logic                  write_en_n;
  logic [NBYTES-1:0]     byte_write_sel_n;
  pzs_pkg::pzs_order_e   burst_order;
  logic                  out_enable_n;
  logic                  sleep_req;
  logic [DW-1:0]         ctrl_dq;
  logic                  ctrl_dq_oe;
  logic [DW-1:0]         dev_dq;
  logic                  dev_dq_oe;
  logic [DW-1:0]         dq_bus;

  // Device wins a clash; a clash means the controller broke the pipeline timing
  assign dq_bus = dev_dq_oe ? dev_dq : ctrl_dq;

  modport dev (
    input  addr, clk_enable_n, advance_load_n, chip_sel1_n, chip_sel2, chip_sel3_n,
    input  write_en_n, byte_write_sel_n, burst_order, out_enable_n, sleep_req, dq_bus,
    output dev_dq, dev_dq_oe
  );

  modport ctrl (
    output addr, clk_enable_n, advance_load_n, chip_sel1_n, chip_sel2, chip_sel3_n,
    output write_en_n, byte_write_sel_n, burst_order, out_enable_n, sleep_req,
    output ctrl_dq, ctrl_dq_oe,
    input  dq_bus
  );
endinterface

// ### design/pzs_sram_ctrl.sv
// Controller end: turns one user command per cycle into SRAM pin cycles.
// Assumes the device end samples the pins on the same clock edge.
`timescale 1ns/10ps
`include "pzs_defs.svh"
module pzs_sram_ctrl #(
  parameter int ADDR_W = `PZS_ADDR_W,
  parameter int NBYTES = `PZS_NBYTES,
  parameter int BYTE_W = `PZS_BYTE_W
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       suspend_i,
  input  wire logic                       cmd_valid_i,
  input  wire logic                       cmd_adv_i,
  input  wire logic                       cmd_write_i,
  input  wire logic [ADDR_W-1:0]          cmd_addr_i,
  input  wire logic [NBYTES*BYTE_W-1:0]   cmd_wdata_i,
  input  wire logic [NBYTES-1:0]          cmd_byte_n_i,
  input  wire logic                       order_linear_i,
  input  wire logic                       out_enable_n_i,
  input  wire logic                       sleep_i,
  output logic                            rd_valid_o,
  output logic [NBYTES*BYTE_W-1:0]        rd_data_o,
  pzs_sram_if.ctrl                        bus
);
  localparam int DW = NBYTES * BYTE_W;

  if (ADDR_W < `PZS_CNT_W || NBYTES < 1 || BYTE_W < 1) begin : g_chk
    $error("pzs_sram_ctrl: unsupported width parameters");
  end

  logic [ADDR_W-1:0]   addr_q, addr_d;
  logic                cen_n_q, cen_n_d, adv_n_q, adv_n_d, cs1_n_q, cs1_n_d, we_n_q, we_n_d;
  logic [NBYTES-1:0]   bwn_q, bwn_d;
  logic                lin_q, oe_n_q, slp_q;
  pzs_pkg::pzs_op_e    pin_op_q, pin_op_d, p1_op_q, p1_op_d, p2_op_q, p2_op_d;
  logic [DW-1:0]       pin_wd_q, pin_wd_d, p1_wd_q, p1_wd_d, dq_q, dq_d;
  logic                dq_oe_q, dq_oe_d, rdv_q, rdv_d;
  logic [DW-1:0]       rdd_q, rdd_d;

  // Pin cycle and data pipeline; the pipeline freezes with the device
  always_comb begin
    addr_d   = addr_q;
    adv_n_d  = adv_n_q;
    cs1_n_d  = cs1_n_q;
    we_n_d   = we_n_q;
    bwn_d    = bwn_q;
    pin_op_d = pin_op_q;
    pin_wd_d = pin_wd_q;
    cen_n_d  = suspend_i;                       // RL4
    p1_op_d  = p1_op_q;
    p1_wd_d  = p1_wd_q;
    p2_op_d  = p2_op_q;
    dq_d     = dq_q;
    dq_oe_d  = dq_oe_q;
    rdd_d    = rdd_q;
    rdv_d    = 1'h0;
    if (!suspend_i) begin
      if (cmd_valid_i) begin
        cs1_n_d  = 1'h0;
        adv_n_d  = cmd_adv_i;                   // RL10
        addr_d   = cmd_addr_i;
        we_n_d   = ~cmd_write_i;                // RL11
        bwn_d    = cmd_byte_n_i;
        pin_op_d = cmd_write_i ? pzs_pkg::PZS_OP_WRITE : pzs_pkg::PZS_OP_READ;
        pin_wd_d = cmd_wdata_i;
      end else begin
        cs1_n_d  = 1'h1;                        // RL5
        adv_n_d  = 1'h0;
        pin_op_d = pzs_pkg::PZS_OP_NONE;
      end
    end
    if (!cen_n_q) begin
      p1_op_d = pin_op_q;
      p1_wd_d = pin_wd_q;
      p2_op_d = p1_op_q;
      dq_d    = p1_wd_q;                        // RL2
      dq_oe_d = (p1_op_q == pzs_pkg::PZS_OP_WRITE); // RL3
      if (p2_op_q == pzs_pkg::PZS_OP_READ) begin
        rdd_d = bus.dq_bus;                     // RL2
        rdv_d = 1'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_q <= '0;
      cen_n_q <= `PZS_PIN_HI_RST;
      adv_n_q <= `PZS_FLAG_RST;
      cs1_n_q <= `PZS_PIN_HI_RST;
      we_n_q <= `PZS_PIN_HI_RST;
      bwn_q <= '1;
      pin_op_q <= pzs_pkg::PZS_OP_NONE;
      pin_wd_q <= '0;
      p1_op_q <= pzs_pkg::PZS_OP_NONE;
      p1_wd_q <= '0;
      p2_op_q <= pzs_pkg::PZS_OP_NONE;
      dq_q <= '0;
      dq_oe_q <= `PZS_FLAG_RST;
      rdd_q <= '0;
      rdv_q <= `PZS_FLAG_RST;
      lin_q <= `PZS_FLAG_RST;
      oe_n_q <= `PZS_PIN_HI_RST;
      slp_q <= `PZS_FLAG_RST;
    end else begin
      addr_q <= addr_d;
      cen_n_q <= cen_n_d;
      adv_n_q <= adv_n_d;
      cs1_n_q <= cs1_n_d;
      we_n_q <= we_n_d;
      bwn_q <= bwn_d;
      pin_op_q <= pin_op_d;
      pin_wd_q <= pin_wd_d;
      p1_op_q <= p1_op_d;
      p1_wd_q <= p1_wd_d;
      p2_op_q <= p2_op_d;
      dq_q <= dq_d;
      dq_oe_q <= dq_oe_d;
      rdd_q <= rdd_d;
      rdv_q <= rdv_d;
      lin_q <= order_linear_i;
      oe_n_q <= out_enable_n_i;
      slp_q <= sleep_i;                         // RL14
    end
  end

  // Only the first select is toggled; the other two stay active
  assign bus.addr             = addr_q;
  assign bus.clk_enable_n     = cen_n_q;
  assign bus.advance_load_n   = adv_n_q;
  assign bus.chip_sel1_n      = cs1_n_q;
  assign bus.chip_sel2        = 1'h1;
  assign bus.chip_sel3_n      = 1'h0;
  assign bus.write_en_n       = we_n_q;
  assign bus.byte_write_sel_n = bwn_q;
  assign bus.burst_order      = lin_q ? pzs_pkg::PZS_ORDER_LINEAR : pzs_pkg::PZS_ORDER_INTERLEAVED;
  assign bus.out_enable_n     = oe_n_q;
  assign bus.sleep_req        = slp_q;
  assign bus.ctrl_dq          = dq_q;
  assign bus.ctrl_dq_oe       = dq_oe_q;
  assign rd_valid_o           = rdv_q;
  assign rd_data_o            = rdd_q;
endmodule

// ### design/pzs_sram_dev.sv
// Device end: synchronous pipelined SRAM with burst counter and byte writes.
// Assumes the controller end keeps two-cycle data timing on the shared bus.
// Operation
// RL1 - Register all synchronous inputs on rising edge
// RL2 - Data appears two cycles after address
// RL3 - Reads and writes follow back to back
// RL4 - Clock enable high freezes every register
// RL5 - Deselect on load starts nothing, ends burst
// RL6 - Pending transfers still complete after deselect
// RL7 - Bus released two cycles after deselect/write
// RL8 - Two-bit counter gives four burst words
// RL9 - Burst-order pin picks linear or interleaved
// RL10 - Advance-load low loads, high steps counter
// RL11 - One read/write pin chooses the operation
// RL12 - Read data driven from output registers
// RL13 - Output enable and burst order are asynchronous
// RL14 - Sleep input may be held low always
// RL15 - Low byte select writes its own lane
// RL16 - Linear adds modulo four, interleaved XORs
`timescale 1ns/10ps
`include "pzs_defs.svh"
module pzs_sram_dev #(
  parameter int ADDR_W = `PZS_ADDR_W,
  parameter int NBYTES = `PZS_NBYTES,
  parameter int BYTE_W = `PZS_BYTE_W
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  output logic                            burst_active_o,
  pzs_sram_if.dev                         bus
);
  localparam int DW    = NBYTES * BYTE_W;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int CW    = `PZS_CNT_W;

  // The counter must span one four-word block and leave address bits above it
  if (ADDR_W <= CW || NBYTES < 1 || BYTE_W < 1 || (1 << CW) != `PZS_BURST_LEN) begin : g_chk
    $error("pzs_sram_dev: unsupported width parameters");
  end

  // Storage is plain flip-flops; a full-size array is slow to simulate
  logic [DW-1:0]       mem_q [DEPTH];
  logic [DW-1:0]       mem_d [DEPTH];

  logic                run;
  logic                sel;
  logic [CW-1:0]       low;

  // Burst state: open flag, loaded address, beat count, kind
  logic                act_q;
  logic                act_d;
  logic [ADDR_W-1:0]   base_q;
  logic [ADDR_W-1:0]   base_d;
  logic [CW-1:0]       cnt_q;
  logic [CW-1:0]       cnt_d;
  logic                bw_q;
  logic                bw_d;

  // Two pipeline stages between address cycle and data cycle
  pzs_pkg::pzs_op_e    s1_op_q;
  pzs_pkg::pzs_op_e    s1_op_d;
  pzs_pkg::pzs_op_e    s2_op_q;
  pzs_pkg::pzs_op_e    s2_op_d;
  logic [ADDR_W-1:0]   s1_addr_q;
  logic [ADDR_W-1:0]   s1_addr_d;
  logic [ADDR_W-1:0]   s2_addr_q;
  logic [ADDR_W-1:0]   s2_addr_d;
  logic [NBYTES-1:0]   s1_bwn_q;
  logic [NBYTES-1:0]   s1_bwn_d;
  logic [NBYTES-1:0]   s2_bwn_q;
  logic [NBYTES-1:0]   s2_bwn_d;

  // Registered read driver
  logic [DW-1:0]       dout_q;
  logic [DW-1:0]       dout_d;
  logic                oe_q;
  logic                oe_d;

  // Data-stage helpers
  logic [DW-1:0]       wmask;
  logic [DW-1:0]       wdata;
  logic                wr_now;
  logic                fwd;

  // Lane mask of the write at the data stage
  for (genvar b = 0; b < NBYTES; b++) begin : g_lane
    assign wmask[b*BYTE_W +: BYTE_W] = {BYTE_W{~s2_bwn_q[b]}}; // RL15
  end

  assign run    = ~bus.clk_enable_n;                          // RL4
  // All three selects active; sleep blocks new loads only
  assign sel    = ~bus.chip_sel1_n &
                  bus.chip_sel2 &
                  ~bus.chip_sel3_n &
                  ~bus.sleep_req;                             // RL14
  assign wr_now = run & (s2_op_q == pzs_pkg::PZS_OP_WRITE);
  assign wdata  = (mem_q[s2_addr_q] & ~wmask) | (bus.dq_bus & wmask); // RL15
  // A read just behind a write to the same word sees the new bytes
  assign fwd    = (s2_op_q == pzs_pkg::PZS_OP_WRITE) && (s2_addr_q == s1_addr_q); // RL3

  // Burst sequencing and command capture
  always_comb begin
    act_d     = act_q;
    base_d    = base_q;
    cnt_d     = cnt_q;
    bw_d      = bw_q;
    s1_op_d   = s1_op_q;
    s1_addr_d = s1_addr_q;
    s1_bwn_d  = s1_bwn_q;
    s2_op_d   = s2_op_q;
    s2_addr_d = s2_addr_q;
    s2_bwn_d  = s2_bwn_q;
    dout_d    = dout_q;
    oe_d      = oe_q;
    low       = '0;
    if (run) begin                                            // RL1
      s1_bwn_d = bus.byte_write_sel_n;                        // RL1
      // Load cycle: new address, or deselect closes the burst
      if (!bus.advance_load_n) begin                          // RL10
        if (sel) begin
          act_d     = 1'h1;
          base_d    = bus.addr;
          cnt_d     = `PZS_CNT_RST;
          bw_d      = ~bus.write_en_n;                        // RL11
          s1_addr_d = bus.addr;
          s1_op_d   = bus.write_en_n ? pzs_pkg::PZS_OP_READ : pzs_pkg::PZS_OP_WRITE; // RL11
        end else begin
          act_d   = 1'h0;                                     // RL5
          s1_op_d = pzs_pkg::PZS_OP_NONE;                     // RL5
        end
      end else if (act_q) begin
        // Advance cycle: counter wraps inside the four-word block
        cnt_d = CW'(cnt_q + 1'b1);                            // RL8
        // Burst order pin is read live, not latched at load
        if (bus.burst_order == pzs_pkg::PZS_ORDER_LINEAR) begin // RL9
          low = CW'(base_q[CW-1:0] + cnt_d);                  // RL16
        end else begin
          low = base_q[CW-1:0] ^ cnt_d;                       // RL16
        end
        s1_addr_d = {base_q[ADDR_W-1:CW], low};               // RL8
        s1_op_d   = bw_q ? pzs_pkg::PZS_OP_WRITE : pzs_pkg::PZS_OP_READ;
      end else begin
        // Advance with no open burst does nothing
        s1_op_d = pzs_pkg::PZS_OP_NONE;
      end
      // Second stage always moves on, so deselect never drops a pending beat
      s2_op_d   = s1_op_q;                                    // RL6
      s2_addr_d = s1_addr_q;
      s2_bwn_d  = s1_bwn_q;
      oe_d      = (s1_op_q == pzs_pkg::PZS_OP_READ);          // RL7
      if (s1_op_q == pzs_pkg::PZS_OP_READ) begin
        dout_d = fwd ? wdata : mem_q[s1_addr_q];              // RL12
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Burst state
      act_q     <= `PZS_FLAG_RST;
      base_q    <= '0;
      cnt_q     <= `PZS_CNT_RST;
      bw_q      <= `PZS_FLAG_RST;
      // Pipeline empties so no stale beat reaches the bus
      s1_op_q   <= pzs_pkg::PZS_OP_NONE;
      s1_addr_q <= '0;
      s1_bwn_q  <= '1;
      s2_op_q   <= pzs_pkg::PZS_OP_NONE;
      s2_addr_q <= '0;
      s2_bwn_q  <= '1;
      // Driver off
      dout_q    <= '0;
      oe_q      <= `PZS_FLAG_RST;
    end else begin
      // Burst state
      act_q     <= act_d;
      base_q    <= base_d;
      cnt_q     <= cnt_d;
      bw_q      <= bw_d;
      // Pipeline stages
      s1_op_q   <= s1_op_d;
      s1_addr_q <= s1_addr_d;
      s1_bwn_q  <= s1_bwn_d;
      s2_op_q   <= s2_op_d;
      s2_addr_q <= s2_addr_d;
      s2_bwn_q  <= s2_bwn_d;
      // Driver
      dout_q    <= dout_d;
      oe_q      <= oe_d;
    end
  end

  // Array write at the data stage; contents are not cleared by reset
  // A read of the word written at the same edge sees the old word; forwarding covers it
  always_comb begin
    mem_d = mem_q;
    if (wr_now) begin
      mem_d[s2_addr_q] = wdata;                               // RL2
    end
  end

  always_ff @(posedge clk_i) begin
    mem_q <= mem_d;
  end

  // Output enable gates the registered driver without the clock
  // so the bus can be freed at any moment, even while suspended
  assign bus.dev_dq    = dout_q;                              // RL12
  assign bus.dev_dq_oe = oe_q & ~bus.out_enable_n;            // RL13
  assign burst_active_o = act_q;
endmodule

// ### dv/pzs_sram_props.sv
// Pin-level checks on the link between the controller and SRAM ends.
// Assumes one clock; the bench instantiates this beside the interface.
`timescale 1ns/10ps
module pzs_sram_props #(
  parameter int NBYTES = 4,
  parameter int BYTE_W = 9
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     clk_enable_n,
  input  wire logic                     advance_load_n,
  input  wire logic                     chip_sel1_n,
  input  wire logic                     chip_sel2,
  input  wire logic                     chip_sel3_n,
  input  wire logic                     write_en_n,
  input  wire logic                     out_enable_n,
  input  wire logic                     sleep_req,
  input  wire logic [NBYTES*BYTE_W-1:0] dev_dq,
  input  wire logic                     dev_dq_oe,
  input  wire logic                     ctrl_dq_oe
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Load decode as the device sees it; sleep blocks loads only
  logic sel;
  logic load;
  assign sel  = !chip_sel1_n && chip_sel2 && !chip_sel3_n && !sleep_req;
  assign load = !clk_enable_n && !advance_load_n;

  // Steps of a transfer; a stalled edge shifts the slot, so enabled edges are required
  sequence rd_ld_s; load && sel && write_en_n; endsequence
  sequence wr_ld_s; load && sel && !write_en_n; endsequence
  sequence off_ld_s; load && !sel; endsequence
  sequence step_s; !clk_enable_n; endsequence
  sequence adv_s; !clk_enable_n && advance_load_n; endsequence

  rd_lat_a: assert property (rd_ld_s ##1 step_s |=> dev_dq_oe || out_enable_n)
    else $error("read data missing two cycles after its address");
  adv_rd_a: assert property (rd_ld_s ##1 adv_s ##1 step_s |=> dev_dq_oe || out_enable_n)
    else $error("burst beat read data missing");
  wr_rel_a: assert property (wr_ld_s ##1 step_s |=> !dev_dq_oe)
    else $error("device drives bus in a write data slot");
  wr_data_a: assert property (wr_ld_s ##1 step_s |=> ctrl_dq_oe)
    else $error("write data not driven two cycles after its address");
  desel_rel_a: assert property (off_ld_s ##1 step_s |=> !dev_dq_oe)
    else $error("device drives bus after a deselect");
  freeze_a: assert property (clk_enable_n |=> $stable(dev_dq))
    else $error("output register moved while clock enable high");
  oe_async_a: assert property (out_enable_n |-> !dev_dq_oe)
    else $error("outputs driven with output enable off");
  no_clash_a: assert property (!(dev_dq_oe && ctrl_dq_oe))
    else $error("both ends drive the data bus");
endmodule

// ### dv/test_pipelined_zero_turnaround_sram.sv
// Self-checking bench: controller and device ends joined by the pin link.
// Assumes design files compile first; 125 MHz clock, synchronous reset.
`timescale 1ns/10ps
module test_pipelined_zero_turnaround_sram;
  localparam int AW = 6;
  localparam int DW = 36;
  logic          clk_i          = 1'b0;
  logic          rst_i          = 1'b1;
  logic          suspend_i      = 1'b0;
  logic          cmd_valid_i    = 1'b0;
  logic          cmd_adv_i      = 1'b0;
  logic          cmd_write_i    = 1'b0;
  logic [AW-1:0] cmd_addr_i     = 6'h00;
  logic [DW-1:0] cmd_wdata_i    = 36'h0;
  logic [3:0]    cmd_byte_n_i   = 4'hF;
  logic          order_linear_i = 1'b1;
  logic          out_enable_n_i = 1'b0;
  logic          rd_valid_o;
  logic [DW-1:0] rd_data_o;
  int            fails          = 0;
  int            cmp_count      = 0;
  // Reference array and read queue; care drops for reads with outputs off
  logic [DW-1:0] mem_m [64];
  logic [DW-1:0] exp_q [$];
  bit            care_q [$];
  bit            care           = 1'b1;
  bit            open_m         = 1'b0;
  bit            kind_m;
  int            base_m;
  int            k_m;

  pzs_sram_if #(.ADDR_W(AW)) bus_if ();
  pzs_sram_ctrl #(.ADDR_W(AW)) i_pzs_sram_ctrl (.clk_i(clk_i), .rst_i(rst_i), .suspend_i(suspend_i),
    .cmd_valid_i(cmd_valid_i), .cmd_adv_i(cmd_adv_i), .cmd_write_i(cmd_write_i), .cmd_addr_i(cmd_addr_i),
    .cmd_wdata_i(cmd_wdata_i), .cmd_byte_n_i(cmd_byte_n_i), .order_linear_i(order_linear_i),
    .out_enable_n_i(out_enable_n_i), .sleep_i(1'b0), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
    .bus(bus_if));
  pzs_sram_dev #(.ADDR_W(AW)) i_pzs_sram_dev (.clk_i(clk_i), .rst_i(rst_i), .burst_active_o(), .bus(bus_if));
  pzs_sram_props i_props (.clk_i(clk_i), .rst_i(rst_i), .clk_enable_n(bus_if.clk_enable_n),
    .advance_load_n(bus_if.advance_load_n), .chip_sel1_n(bus_if.chip_sel1_n), .chip_sel2(bus_if.chip_sel2),
    .chip_sel3_n(bus_if.chip_sel3_n), .write_en_n(bus_if.write_en_n), .out_enable_n(bus_if.out_enable_n),
    .sleep_req(bus_if.sleep_req), .dev_dq(bus_if.dev_dq), .dev_dq_oe(bus_if.dev_dq_oe),
    .ctrl_dq_oe(bus_if.ctrl_dq_oe));

  // 8 ns clock
  initial begin
    forever #4 clk_i = ~clk_i;
  end

  task automatic check(input string what, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One user beat; a suspended beat is swallowed whole, so the model skips it
  task automatic beat(input bit s, v, adv, wr, input int a, input logic [3:0] bn);
    logic [DW-1:0] d;
    int            ea;
    d = DW'({$urandom(), $urandom()});
    @(posedge clk_i);
    suspend_i    <= s;
    cmd_valid_i  <= v;
    cmd_adv_i    <= adv;
    cmd_write_i  <= wr;
    cmd_addr_i   <= AW'(a);
    cmd_wdata_i  <= d;
    cmd_byte_n_i <= bn;
    if (s) return;
    if (!v) open_m = 0;
    if (!v) return;
    if (!adv) begin
      open_m = 1;
      kind_m = wr;
      base_m = a;
      k_m    = 0;
    end else begin
      k_m++;
    end
    ea = (base_m & 60) | (order_linear_i ? (base_m + k_m) & 3 : (base_m ^ k_m) & 3);
    if (kind_m) begin
      for (int b = 0; b < 4; b++) if (!bn[b]) mem_m[ea][9*b +: 9] = d[9*b +: 9];
    end else begin
      exp_q.push_back(mem_m[ea]);
      care_q.push_back(care);
    end
  endtask

  // Random mix of deselects, loads and burst beats with random stalls
  task automatic rand_run(input int n);
    int r;
    for (int i = 0; i < n; i++) begin
      r = $urandom % 8;
      if (r == 0) beat($urandom % 6 == 0, 0, 0, 0, 0, 4'hF);
      else if (r > 3 && open_m) beat($urandom % 6 == 0, 1, 1, kind_m, 0, 4'($urandom));
      else beat($urandom % 6 == 0, 1, 0, r[0], $urandom % 64, 4'($urandom));
    end
  endtask

  // Idle the bus and wait, bounded, for all reads to return
  task automatic drain(input string name);
    int i;
    beat(0, 0, 0, 0, 0, 4'hF);
    for (i = 0; i < 20 && exp_q.size() != 0; i++) @(posedge clk_i);
    check("pending_reads", DW'(exp_q.size()), 36'h0);
    $display("Test %s done, %0d mismatches", name, fails);
    if (i == 20) report_and_stop();
  endtask

  // Each returned word whose care flag is set is compared with the model in issue order
  always @(negedge clk_i) begin
    if (!rst_i && rd_valid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("read_extra", 36'h1, 36'h0);
      end else if (care_q.pop_front()) begin
        check("read_data", rd_data_o, exp_q.pop_front());
      end else begin
        void'(exp_q.pop_front());
      end
    end
  end

  // Main sequence
  initial begin
    void'($urandom(32'hE713));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 64; a++) beat(0, 1, 0, 1, a, 4'h0);
    drain("fill");
    rand_run(300);
    drain("linear");
    order_linear_i <= 1'b0;
    rand_run(300);
    drain("interleaved");
    // Outputs off: reads still run but the device must leave the bus alone
    out_enable_n_i <= 1'b1;
    care = 0;
    repeat (2) beat(0, 0, 0, 0, 0, 4'hF);
    for (int a = 0; a < 4; a++) beat(0, 1, 0, 0, a, 4'hF);
    repeat (5) beat(0, 0, 0, 0, 0, 4'hF);
    out_enable_n_i <= 1'b0;
    care = 1;
    drain("outputs_off");
    report_and_stop();
  end
endmodule
